// ==== hw/smc_sleep_ctrl.sv ====
/*
 Sleep mode controller: control register over AXI4-Lite, sleep entry,
 clock and oscillator gating per mode, wake source filtering and
 wake-up delays. Assumes the core pulses a sleep request on the same
 clock; wake sources come from pins or other domains and are synced.
*/
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_ctrl #(
    parameter int STARTUP_CYC = 16, // Default start-up cycles, used when the fuse reads zero
    parameter int CNT_W = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // AXI4-Lite slave
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Core side
    input wire logic SLEEP_EXEC,
    input wire logic ADC_ENABLED,
    input wire logic CRYSTAL_SEL,
    input wire logic [CNT_W-1:0] STARTUP_FUSE_CYC,
    // Wake sources, asynchronous
    input wire logic ANY_IRQ,
    input wire logic ADC_DONE_IRQ,
    input wire logic EXT_RESET,
    input wire logic WDT_RESET,
    input wire logic WDT_IRQ,
    input wire logic BOD_RESET,
    input wire logic TWI_IRQ,
    input wire logic TWI_ADDR_MATCH,
    input wire logic SPM_READY_IRQ,
    input wire logic EXT_IRQ_LINE6_LEVEL,
    input wire logic [3:0] EXT_IRQ_LINES_LOW,
    input wire logic PIN_CHANGE_IRQ,
    input wire logic BUS_POWER_TRANSITION_IRQ,
    input wire logic USB_WAKE_IRQ,
    // Clock gates, high means clock runs; then conversion start and status
    output logic CORE_CLOCK_EN,
    output logic PROGRAM_MEMORY_CLOCK_EN,
    output logic PERIPHERAL_CLOCK_EN,
    output logic ADC_CLOCK_EN,
    output logic USB_CLOCK_EN,
    output logic OSC_EN,
    output logic ADC_START,
    output logic WAKE_BY_RESET,
    output logic SLEEPING
);
    // Elaboration check: the counter must hold the default start-up
    if (CNT_W < 4 || CNT_W > 30 || STARTUP_CYC < 1 ||
            STARTUP_CYC >= (1 << CNT_W)) begin : g_bad_cnt
        $error("smc_sleep_ctrl: bad counter parameters");
    end

    // Costs two cycles of wake latency, keeps metastability out
    localparam int NSRC = 17; // Synchronised wake inputs

    // Control register: low four bits only
    logic [3:0] control_r;
    smc_pkg::smc_state_type state_r;
    logic [2:0] mode_r; // Mode latched at entry
    logic [CNT_W-1:0] cnt_r;
    logic by_reset_r;

    // Two-flop synchroniser, first stage read by second only
    logic [NSRC-1:0] src_meta_r;
    logic [NSRC-1:0] src_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            src_meta_r <= '0;
            src_r <= '0;
        end else if (CLK_EN) begin
            src_meta_r <= {ANY_IRQ, ADC_DONE_IRQ, EXT_RESET, WDT_RESET,
                WDT_IRQ, BOD_RESET, TWI_IRQ, TWI_ADDR_MATCH,
                SPM_READY_IRQ, EXT_IRQ_LINE6_LEVEL, EXT_IRQ_LINES_LOW,
                PIN_CHANGE_IRQ, BUS_POWER_TRANSITION_IRQ, USB_WAKE_IRQ};
            src_r <= src_meta_r;
        end
    end

    // Named views of the synchronised sources
    logic s_any, s_adc, s_xrst, s_wrst, s_wirq, s_bod, s_twi, s_twam;
    logic s_spm, s_l6, s_pc, s_vbus, s_uwk;
    logic [3:0] s_low;
    assign {s_any, s_adc, s_xrst, s_wrst, s_wirq, s_bod, s_twi, s_twam,
        s_spm, s_l6, s_low, s_pc, s_vbus, s_uwk} = src_r;

    // Wake qualification per latched mode
    logic resets_any;
    logic pins_any;
    logic irq_wake;
    logic standby_mode;
    assign resets_any = s_xrst | s_wrst | s_bod;
    assign pins_any = s_l6 | (|s_low) | s_pc; // Line six level, low lines and pin change
    assign standby_mode = (mode_r == smc_pkg::SMC_MODE_STBY) ||
        (mode_r == smc_pkg::SMC_MODE_XSTBY);
    always_comb begin
        irq_wake = 1'b0;
        unique case (mode_r)
            smc_pkg::SMC_MODE_IDLE:
                // Every interrupt counts here, pin lines included
                irq_wake = s_any | s_adc | s_wirq | s_twi | s_twam |
                    s_spm | pins_any | s_vbus | s_uwk;
            smc_pkg::SMC_MODE_ADCNR:
                irq_wake = s_adc | s_wirq | s_twi | s_spm | pins_any;
            smc_pkg::SMC_MODE_PDOWN, smc_pkg::SMC_MODE_PSAVE,
            smc_pkg::SMC_MODE_STBY, smc_pkg::SMC_MODE_XSTBY:
                // Same set for all four modes
                irq_wake = s_twam | pins_any | s_vbus | s_uwk;
            default:
                // Reserved codes: no wake besides reset
                irq_wake = 1'b0;
        endcase
    end

    // Valid sleep entry decode
    // Illegal requests simply leave the core running
    logic mode_legal;
    logic [2:0] ctl_mode;
    assign ctl_mode = control_r[smc_pkg::SMC_SM_LSB +: 3];
    always_comb begin
        unique case (ctl_mode)
            smc_pkg::SMC_MODE_IDLE, smc_pkg::SMC_MODE_ADCNR,
            smc_pkg::SMC_MODE_PDOWN, smc_pkg::SMC_MODE_PSAVE:
                mode_legal = 1'b1;
            // Standby needs a crystal option
            smc_pkg::SMC_MODE_STBY, smc_pkg::SMC_MODE_XSTBY:
                mode_legal = CRYSTAL_SEL;
            default:
                // Reserved codes never sleep
                mode_legal = 1'b0;
        endcase
    end

    // Sleep sequencer
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= smc_pkg::SMC_ACTIVE;
            mode_r <= smc_pkg::SMC_MODE_IDLE;
            cnt_r <= '0;
            by_reset_r <= 1'b0;
        end else if (CLK_EN) begin
            unique case (state_r)
                smc_pkg::SMC_ACTIVE: begin
                    // Only with enable set does the instruction sleep
                    if (SLEEP_EXEC && control_r[smc_pkg::SMC_SE_BIT] &&
                            mode_legal) begin
                        state_r <= smc_pkg::SMC_ASLEEP;
                        mode_r <= ctl_mode;
                        by_reset_r <= 1'b0;
                    end
                end
                smc_pkg::SMC_ASLEEP: begin
                    // Reset wins over interrupt as the wake cause
                    if (resets_any || irq_wake) begin
                        by_reset_r <= resets_any;
                        state_r <= smc_pkg::SMC_STARTUP;
                        // Start-up length by mode
                        if (standby_mode) begin
                            cnt_r <= CNT_W'(smc_pkg::SMC_STANDBY_WAKE_CYC);
                        end else if (mode_r == smc_pkg::SMC_MODE_PDOWN ||
                                mode_r == smc_pkg::SMC_MODE_PSAVE) begin
                            // Oscillator restart, fuse chosen
                            cnt_r <= (STARTUP_FUSE_CYC == '0) ?
                                CNT_W'(STARTUP_CYC) : STARTUP_FUSE_CYC;
                        end else begin
                            cnt_r <= CNT_W'(1); // Oscillator never stopped
                        end
                    end
                end
                smc_pkg::SMC_STARTUP: begin
                    // Count down the restart delay
                    if (cnt_r > CNT_W'(1)) begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end else if (by_reset_r) begin
                        // Reset restarts from vector, no extra halt
                        state_r <= smc_pkg::SMC_ACTIVE;
                    end else begin
                        state_r <= smc_pkg::SMC_HALT;
                        cnt_r <= CNT_W'(smc_pkg::SMC_IRQ_HALT_CYC);
                    end
                end
                smc_pkg::SMC_HALT: begin
                    // Extra core halt before the handler runs
                    if (cnt_r > CNT_W'(1)) begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end else begin
                        state_r <= smc_pkg::SMC_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Clock gating outputs, registered
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CORE_CLOCK_EN <= 1'b1;
            PROGRAM_MEMORY_CLOCK_EN <= 1'b1;
            PERIPHERAL_CLOCK_EN <= 1'b1;
            ADC_CLOCK_EN <= 1'b1;
            USB_CLOCK_EN <= 1'b1;
            OSC_EN <= 1'b1;
            SLEEPING <= 1'b0;
            WAKE_BY_RESET <= 1'b0;
        end else if (CLK_EN) begin
            // Busy covers start-up and halt as well
            SLEEPING <= (state_r != smc_pkg::SMC_ACTIVE);
            WAKE_BY_RESET <= by_reset_r;
            if (state_r == smc_pkg::SMC_ACTIVE) begin
                {CORE_CLOCK_EN, PROGRAM_MEMORY_CLOCK_EN, PERIPHERAL_CLOCK_EN,
                    ADC_CLOCK_EN, USB_CLOCK_EN, OSC_EN} <= 6'h3f;
            end else if (state_r == smc_pkg::SMC_ASLEEP) begin
                // Core and program memory stop in every mode
                CORE_CLOCK_EN <= 1'b0;
                PROGRAM_MEMORY_CLOCK_EN <= 1'b0;
                PERIPHERAL_CLOCK_EN <= (mode_r == smc_pkg::SMC_MODE_IDLE);
                ADC_CLOCK_EN <= (mode_r == smc_pkg::SMC_MODE_IDLE) ||
                    (mode_r == smc_pkg::SMC_MODE_ADCNR);
                USB_CLOCK_EN <= (mode_r == smc_pkg::SMC_MODE_IDLE) ||
                    (mode_r == smc_pkg::SMC_MODE_ADCNR);
                // Oscillator off only in power-down and power-save
                OSC_EN <= !(mode_r == smc_pkg::SMC_MODE_PDOWN ||
                    mode_r == smc_pkg::SMC_MODE_PSAVE);
            end else begin
                // Start-up: oscillator back, core still halted
                OSC_EN <= 1'b1;
            end
        end
    end

    // One-cycle conversion start on entry
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ADC_START <= 1'b0;
        end else if (CLK_EN) begin
            // Same terms as entry, so no start without sleep
            ADC_START <= (state_r == smc_pkg::SMC_ACTIVE) && SLEEP_EXEC &&
                control_r[smc_pkg::SMC_SE_BIT] && mode_legal && ADC_ENABLED &&
                (ctl_mode == smc_pkg::SMC_MODE_IDLE ||
                 ctl_mode == smc_pkg::SMC_MODE_ADCNR);
        end
    end

    // AXI write: take address and data in either order
    // Readies are flops, low from take until the response is taken
    logic aw_held_r, w_held_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= smc_pkg::SMC_RESP_OKAY;
            control_r <= smc_pkg::SMC_CONTROL_RESET;
        end else if (CLK_EN) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                S_AXI_WREADY <= 1'b0;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (aw_held_r && w_held_r && !S_AXI_BVALID) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (aw_addr_r == smc_pkg::SMC_ADDR_CONTROL) begin
                    S_AXI_BRESP <= smc_pkg::SMC_RESP_OKAY;
                    // Upper bits are not stored, read as zero
                    if (w_strb_r[0])
                        control_r <= w_data_r[3:0];
                end else if (aw_addr_r == smc_pkg::SMC_ADDR_STATUS) begin
                    S_AXI_BRESP <= smc_pkg::SMC_RESP_OKAY; // Read-only
                end else begin
                    S_AXI_BRESP <= smc_pkg::SMC_RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                // Both channels open again for the next write
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // AXI read: answer one cycle after address
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= smc_pkg::SMC_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= smc_pkg::SMC_RESP_OKAY;
                if (S_AXI_ARADDR == smc_pkg::SMC_ADDR_CONTROL) begin
                    S_AXI_RDATA <= {28'h0, control_r};
                end else if (S_AXI_ARADDR == smc_pkg::SMC_ADDR_STATUS) begin
                    // Sequencer state and latched mode
                    S_AXI_RDATA <= {24'h0, by_reset_r, mode_r, 2'h0, state_r};
                end else begin
                    // Unmapped offsets answer an error, data zero
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= smc_pkg::SMC_RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/smc_pkg.sv ====
/*
 Constants for the sleep mode controller: register map, field
 positions, mode codes and wake timing. Assumes a 25 MHz system clock.
*/
// What this block does
// - Control register: mode field, enable, upper zero
// - Sleep instruction sleeps only when enabled
// - Mode 000 idle stops core, memory clocks
// - Idle wakes on any enabled interrupt
// - Idle or noise mode starts conversion
// - Mode 001 also stops peripheral clock
// - Noise mode wakes on listed sources only
// - Mode 010 power-down stops oscillator, all clocks
// - Power-down wakes on listed asynchronous sources
// - Power-down wake waits fuse-defined start-up delay
// - Mode 011 behaves exactly like power-down
// - Mode 110 standby keeps oscillator running
// - Standby wake resumes after six cycles
// - Mode 111 extended standby equals standby
// - Interrupt wake adds four halt cycles
package smc_pkg;
    // Register byte addresses
    localparam logic [3:0] SMC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] SMC_ADDR_STATUS = 4'h4;
    // Control field positions
    localparam int SMC_SE_BIT = 0;
    localparam int SMC_SM_LSB = 1;
    localparam logic [3:0] SMC_CONTROL_RESET = 4'h0;
    // Mode codes
    localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
    localparam logic [2:0] SMC_MODE_ADCNR = 3'h1;
    localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SMC_MODE_STBY = 3'h6;
    localparam logic [2:0] SMC_MODE_XSTBY = 3'h7;
    // Wake timing in cycles
    localparam int SMC_STANDBY_WAKE_CYC = 6;
    localparam int SMC_IRQ_HALT_CYC = 4;
    // AXI responses
    localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;
    // Sequencer states
    typedef enum logic [1:0] {
        SMC_ACTIVE = 2'b00,
        SMC_ASLEEP = 2'b01,
        SMC_STARTUP = 2'b10,
        SMC_HALT = 2'b11
    } smc_state_type;
endpackage

// ==== tb/smc_sleep_checker.sv ====
/*
 Checker for the sleep mode controller, watching top-level ports only.
 Assumes CLK_EN is held high, so every edge advances the design.
*/
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_checker (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SLEEP_EXEC,
    input wire logic ADC_ENABLED,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic CORE_CLOCK_EN,
    input wire logic PROGRAM_MEMORY_CLOCK_EN,
    input wire logic PERIPHERAL_CLOCK_EN,
    input wire logic ADC_CLOCK_EN,
    input wire logic USB_CLOCK_EN,
    input wire logic OSC_EN,
    input wire logic ADC_START,
    input wire logic SLEEPING
);
    // One domain, so one clock and one reset for all
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Upper byte lanes never carry register data
    property p_rd_hi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read high bits set");
    // Sleep only follows the core's sleep pulse
    property p_cause; $rose(SLEEPING) |-> $past(SLEEP_EXEC, 2); endproperty
    a_cause: assert property (p_cause) else $error("sleep without cause");
    // Core and program memory clocks always gate together
    property p_core; CORE_CLOCK_EN == PROGRAM_MEMORY_CLOCK_EN; endproperty
    a_core: assert property (p_core) else $error("core gates split");
    // Peripheral clock only stops with the core stopped
    property p_per; !PERIPHERAL_CLOCK_EN |-> !CORE_CLOCK_EN; endproperty
    a_per: assert property (p_per) else $error("peripheral gate alone");
    // ADC clock off means the peripheral clock is off too
    property p_adc; !ADC_CLOCK_EN |-> !PERIPHERAL_CLOCK_EN; endproperty
    a_adc: assert property (p_adc) else $error("adc gate wrong");
    // Stopped oscillator leaves no peripheral, ADC or USB clock
    property p_osc;
        !OSC_EN |-> !ADC_CLOCK_EN && !USB_CLOCK_EN && !PERIPHERAL_CLOCK_EN;
    endproperty
    a_osc: assert property (p_osc) else $error("clock with osc off");
    // Conversion start needs sleep entry with converter on
    property p_start; ADC_START |-> $past(SLEEP_EXEC) && $past(ADC_ENABLED);
    endproperty
    a_start: assert property (p_start) else $error("stray adc start");
    // Start is a single-cycle pulse
    property p_pulse; ADC_START |=> !ADC_START; endproperty
    a_pulse: assert property (p_pulse) else $error("adc start too long");
    // Write response holds until taken
    property p_bhold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    // Read data holds until taken
    property p_rhold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    // Main scenarios
    c_enter: cover property ($rose(SLEEPING));
    c_osc: cover property ($fell(OSC_EN));
    c_start: cover property (ADC_START);
    c_wake: cover property ($fell(SLEEPING));
endmodule
bind smc_sleep_ctrl smc_sleep_checker chk_u (.SYS_CLK, .RST_N, .SLEEP_EXEC,
    .ADC_ENABLED, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .S_AXI_RDATA, .CORE_CLOCK_EN, .PROGRAM_MEMORY_CLOCK_EN,
    .PERIPHERAL_CLOCK_EN, .ADC_CLOCK_EN, .USB_CLOCK_EN, .OSC_EN, .ADC_START,
    .SLEEPING);
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the sleep mode controller: register access,
 a table of sleep modes, wake filtering and wake timing.
 Assumes the design package is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int STARTUP = 10; // Short default start-up keeps runs brief
    localparam logic [3:0] CTL = smc_pkg::SMC_ADDR_CONTROL;
    localparam logic [1:0] ERR = smc_pkg::SMC_RESP_SLVERR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic sleep_exec = 1'b0, adc_en = 1'b0, xtal = 1'b0;
    logic [15:0] fuse = 16'h0; // Fuse delay, zero takes the default
    int starts = 0; // Conversion start pulses seen
    logic [16:0] wv = 17'h0; // Wake sources, see port map
    wire awready, wready, bvalid, arready, rvalid, adc_start, wbr, sleeping;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] en; // Core, memory, peripheral, adc, usb, oscillator
    int err_total = 0;
    int checked = 0;
    int dur[10];
    int n;
    logic [31:0] d;
    logic [1:0] r;
    // Rows: mode, enable, crystal, asleep, expected clock enables
    logic [11:0] rows[10] = '{12'h14f, 12'h347, 12'h540, 12'h740, 12'hdc1,
        12'hfc1, 12'h43f, 12'h93f, 12'hb3f, 12'hd3f};
    smc_sleep_ctrl #(.STARTUP_CYC(STARTUP), .CNT_W(16)) dut_u (
        .SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .SLEEP_EXEC(sleep_exec), .ADC_ENABLED(adc_en),
        .CRYSTAL_SEL(xtal), .STARTUP_FUSE_CYC(fuse), .ANY_IRQ(wv[0]),
        .ADC_DONE_IRQ(wv[1]), .EXT_RESET(wv[2]), .WDT_RESET(wv[3]),
        .WDT_IRQ(wv[4]), .BOD_RESET(wv[5]), .TWI_IRQ(wv[6]),
        .TWI_ADDR_MATCH(wv[7]), .SPM_READY_IRQ(wv[8]),
        .EXT_IRQ_LINE6_LEVEL(wv[9]), .EXT_IRQ_LINES_LOW(wv[13:10]),
        .PIN_CHANGE_IRQ(wv[14]), .BUS_POWER_TRANSITION_IRQ(wv[15]),
        .USB_WAKE_IRQ(wv[16]), .CORE_CLOCK_EN(en[5]),
        .PROGRAM_MEMORY_CLOCK_EN(en[4]), .PERIPHERAL_CLOCK_EN(en[3]),
        .ADC_CLOCK_EN(en[2]), .USB_CLOCK_EN(en[1]), .OSC_EN(en[0]),
        .ADC_START(adc_start), .WAKE_BY_RESET(wbr), .SLEEPING(sleeping));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Count conversion start pulses
    always @(posedge clk) if (adc_start === 1'b1) starts <= starts + 1;
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Write: both channels offered, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (tb !== 1'b1);
        bready <= 1'b0;
        @(posedge clk); // Keeps back-to-back calls from double driving
    endtask
    // Read one word
    task automatic axr(input logic [3:0] a);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end while (tr !== 1'b1);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // Program control, then pulse the sleep instruction
    task automatic slp(input logic [3:0] c);
        axw(CTL, {28'h0, c});
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Raise one source, count cycles until awake
    task automatic wake(input int i, output int cnt);
        cnt = 0;
        wv[i] <= 1'b1;
        do begin
            @(negedge clk);
            cnt++;
        end while (sleeping === 1'b1 && cnt < 200);
        @(posedge clk);
        wv[i] <= 1'b0;
        repeat (4) @(posedge clk);
        chk("enables after wake", en, 6'h3f);
    endtask
    // A source that must not wake this mode
    task automatic stay(input int i);
        wv[i] <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("still asleep", sleeping, 1'b1);
        @(posedge clk);
        wv[i] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Verdict, one place for both endings
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well beyond the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset enables", en, 6'h3f);
        chk("reset sleeping", sleeping, 1'b0);
        @(posedge clk);
        axr(CTL);
        chk("control reset", d, 32'h0);
        axw(CTL, 32'hff);
        axr(CTL);
        chk("control upper", d, 32'hf);
        axr(4'h8);
        chk("unmapped read", r, ERR);
        axw(4'hc, 32'h1);
        chk("unmapped write", r, ERR);
        $display("test registers done");
        // Every mode code, disabled sleep and missing crystal
        foreach (rows[i]) begin
            xtal <= rows[i][7];
            adc_en <= 1'b1;
            n = starts;
            slp(rows[i][11:8]);
            @(negedge clk);
            chk("asleep", sleeping, rows[i][6]);
            chk("gates", en, rows[i][5:0]);
            chk("adc start", starts - n,
                rows[i][11:10] == 2'h0 && rows[i][6]);
            @(posedge clk);
            dur[i] = 0;
            if (rows[i][6]) wake(10, dur[i]);
            axw(CTL, 32'h0);
        end
        chk("standby wake", dur[4] - dur[0], 5);
        chk("extended standby", dur[5], dur[4]);
        chk("power-down wake", dur[2] - dur[0], STARTUP - 1);
        chk("power-save", dur[3], dur[2]);
        $display("test mode table done");
        slp({smc_pkg::SMC_MODE_IDLE, 1'b1});
        wake(0, n);
        chk("idle irq wake", n, dur[0]);
        slp({smc_pkg::SMC_MODE_ADCNR, 1'b1});
        stay(0);
        wake(1, n);
        chk("noise mode wake", n, dur[0]);
        slp({smc_pkg::SMC_MODE_PDOWN, 1'b1});
        stay(1);
        stay(6);
        wake(16, n);
        chk("usb wake", n, dur[2]);
        fuse <= 16'h14;
        slp({smc_pkg::SMC_MODE_PDOWN, 1'b1});
        wake(10, n);
        chk("fuse wake", n - dur[2], 32'h14 - STARTUP);
        fuse <= 16'h0;
        slp({smc_pkg::SMC_MODE_IDLE, 1'b1});
        wake(2, n);
        chk("reset skips halt", dur[0] - n, 4);
        @(negedge clk);
        chk("wake by reset", wbr, 1'b1);
        @(posedge clk);
        $display("test wake sources done");
        test_done;
    end
endmodule
`default_nettype wire
